// file: hw/map_entry_translator.sv
// page map entry translator with axi4-lite registers and entry fetch port
// Functional notes
// - owner bits never examined nor altered
// - bits 22:21 carry no processor meaning
// - frame number gives upper 21 address bits
// - frame used when entry is valid or bits 22 and 26 are clear
// - frame valid: bit31, or 22/26/31 clear
// - bit22 alone set: shared table index
// - decode yields frame, shared index, or abort
// - private shared table base register, software loads
// - second entry via base plus index, valid
// - access code taken from first entry
// - optional protection and dirty follow processor
// - private system table base and length
// - entries moved as aligned 32-bit longwords
// - longword writes atomic, locked across update
// - system address: 2, page index, offset
// - bit31 valid flag gates dirty and frame
// - access code checked first, even invalid
// - dirty set on valid write, never inaccessible
//
// Register access over AXI4-Lite and the address map were left to the implementer.
module map_entry_translator
    import map_entry_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    output logic mem_req,
    output logic mem_we,
    output logic mem_lock,
    output logic [PADDR_W-1:0] mem_addr,
    output logic [31:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata
);
    // ==========================================
    // helpers
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    // only bits 31, 26 and 22 select; owner and os bits stay untouched
    function automatic entry_kind_type io_decode(input logic [31:0] e);
        if (e[VALID_BIT] || (!e[SHARED_SEL_BIT] && !e[DIRTY_BIT]))
        begin
            return KIND_FRAME;
        end
        else if (e[SHARED_SEL_BIT] && !e[DIRTY_BIT])
        begin
            return KIND_SHARED;
        end
        return KIND_ABORT;
    endfunction : io_decode

    function automatic logic code_denied(input logic [31:0] e);
        return (e[CODE_HI:CODE_LO] == CODE_NO_ACCESS) || (e[CODE_HI:CODE_LO] == CODE_RESERVED);
    endfunction : code_denied

    // entry address inside the system map table, longword aligned
    function automatic logic [PADDR_W-1:0] entry_addr(input logic [31:0] base,
                                                      input logic [FRAME_W-1:0] idx);
        return base[PADDR_W-1:0] + {7'h00, idx, 2'h0};
    endfunction : entry_addr

    // ==========================================
    // registers
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic do_write;
    logic start;
    logic ctrl_write;
    logic ctrl_dirty_en;
    logic ctrl_access_code_en;
    logic [31:0] vaddr;
    logic [31:0] sys_base;
    logic [31:0] sys_len;
    logic [31:0] shared_table_base_reg;
    logic [PADDR_W-1:0] paddr_res;
    logic [31:0] entry1;
    logic [31:0] entry_final;
    logic [31:0] shared_va;
    logic busy;
    logic done;
    logic abort;
    logic length_fault;
    logic access_fault;
    logic undefined;
    walk_state_type state;
    logic [31:0] read_value;
    logic read_hit;

    assign do_write = aw_held && w_held && !bvalid;
    assign start = do_write && (aw_addr_q == CTRL_OFFSET) && w_strb_q[0]
                   && w_data_q[CTRL_START_BIT] && !busy;

    // ==========================================
    // axi write channels
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready <= 1'b1;
            wready <= 1'b1;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= REG_RESET;
            w_strb_q <= 4'h0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end
        else
        begin
            if (awvalid && awready)
            begin
                aw_addr_q <= awaddr;
                aw_held <= 1'b1;
                awready <= 1'b0;
            end
            if (wvalid && wready)
            begin
                w_data_q <= wdata;
                w_strb_q <= wstrb;
                w_held <= 1'b1;
                wready <= 1'b0;
            end
            if (do_write)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                bvalid <= 1'b1;
                bresp <= (aw_addr_q <= SHARED_BASE_OFFSET && aw_addr_q[1:0] == 2'h0
                          && aw_addr_q != STATUS_OFFSET) ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid && bready)
            begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // ==========================================
    // software registers, private copies kept by this block
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_write <= 1'b0;
            ctrl_dirty_en <= 1'b0;
            ctrl_access_code_en <= 1'b0;
            vaddr <= REG_RESET;
            sys_base <= REG_RESET;
            sys_len <= REG_RESET;
            shared_table_base_reg <= REG_RESET;
        end
        else if (do_write && !busy)
        begin
            // settings frozen during a walk so one request sees one table
            case (aw_addr_q)
                CTRL_OFFSET:
                begin
                    if (w_strb_q[0])
                    begin
                        ctrl_write <= w_data_q[CTRL_WRITE_BIT];
                        ctrl_dirty_en <= w_data_q[CTRL_DIRTY_EN_BIT];
                        ctrl_access_code_en <= w_data_q[CTRL_ACCESS_CODE_EN_BIT];
                    end
                end
                VADDR_OFFSET: vaddr <= merge(vaddr, w_data_q, w_strb_q);
                SYS_BASE_OFFSET: sys_base <= merge(sys_base, w_data_q, w_strb_q);
                SYS_LEN_OFFSET: sys_len <= merge(sys_len, w_data_q, w_strb_q);
                SHARED_BASE_OFFSET:
                    shared_table_base_reg <= merge(shared_table_base_reg, w_data_q,
                                                   w_strb_q);
                default: ;
            endcase
        end
    end

    // ==========================================
    // axi read channel
    always_comb
    begin
        read_value = REG_RESET;
        read_hit = 1'b1;
        case (araddr)
            CTRL_OFFSET: read_value = {28'h0000000, ctrl_access_code_en, ctrl_dirty_en, ctrl_write, 1'b0};
            STATUS_OFFSET: read_value = {26'h0000000, undefined, access_fault, length_fault,
                                         abort, done, busy};
            VADDR_OFFSET: read_value = vaddr;
            SYS_BASE_OFFSET: read_value = sys_base;
            SYS_LEN_OFFSET: read_value = sys_len;
            SHARED_BASE_OFFSET: read_value = shared_table_base_reg;
            PADDR_OFFSET: read_value = {2'h0, paddr_res};
            ENTRY_OFFSET: read_value = entry1;
            FINAL_ENTRY_OFFSET: read_value = entry_final;
            default: read_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= REG_RESET;
            rresp <= RESP_OKAY;
        end
        else
        begin
            if (arvalid && arready)
            begin
                rdata <= read_value;
                rresp <= read_hit ? RESP_OKAY : RESP_SLVERR;
                rvalid <= 1'b1;
                arready <= 1'b0;
            end
            if (rvalid && rready)
            begin
                rvalid <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

    // ==========================================
    // translation walk
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state <= ST_IDLE;
            busy <= 1'b0;
            done <= 1'b0;
            abort <= 1'b0;
            length_fault <= 1'b0;
            access_fault <= 1'b0;
            undefined <= 1'b0;
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_lock <= 1'b0;
            mem_addr <= '0;
            mem_wdata <= REG_RESET;
            paddr_res <= '0;
            entry1 <= REG_RESET;
            entry_final <= REG_RESET;
            shared_va <= REG_RESET;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    if (start)
                    begin
                        done <= 1'b0;
                        abort <= 1'b0;
                        length_fault <= 1'b0;
                        access_fault <= 1'b0;
                        undefined <= 1'b0;
                        if (vaddr[31:30] != SYS_SPACE)
                        begin
                            abort <= 1'b1;
                            done <= 1'b1;
                        end
                        else if ({11'h000, vaddr[PAGE_HI:PAGE_LO]} >= sys_len)
                        begin
                            length_fault <= 1'b1;
                            done <= 1'b1;
                        end
                        else
                        begin
                            busy <= 1'b1;
                            // lock held across fetch and dirty update; taken from the
                            // starting write, since the control bits land on this same edge
                            mem_lock <= w_data_q[CTRL_WRITE_BIT]
                                        && w_data_q[CTRL_DIRTY_EN_BIT];
                            mem_req <= 1'b1;
                            mem_we <= 1'b0;
                            mem_addr <= entry_addr(sys_base, vaddr[PAGE_HI:PAGE_LO]);
                            state <= ST_FETCH1;
                        end
                    end
                end
                ST_FETCH1:
                begin
                    if (mem_ack)
                    begin
                        mem_req <= 1'b0;
                        entry1 <= mem_rdata;
                        entry_final <= mem_rdata;
                        state <= ST_IDLE;
                        if (ctrl_access_code_en && code_denied(mem_rdata))
                        begin
                            access_fault <= 1'b1;
                        end
                        else if (io_decode(mem_rdata) == KIND_FRAME)
                        begin
                            paddr_res <= {mem_rdata[FRAME_HI:0], vaddr[OFFSET_W-1:0]};
                            if (ctrl_write && ctrl_dirty_en && mem_rdata[VALID_BIT])
                            begin
                                // whole longword rewritten, other fields kept as read
                                mem_req <= 1'b1;
                                mem_we <= 1'b1;
                                mem_wdata <= mem_rdata | (32'h1 << DIRTY_BIT);
                                state <= ST_WRBACK;
                            end
                        end
                        else if (io_decode(mem_rdata) == KIND_SHARED)
                        begin
                            // index scaled to longwords from the base's system address
                            shared_va <= shared_table_base_reg + {9'h000, mem_rdata[FRAME_HI:0],
                                                                  2'h0};
                            state <= ST_FETCH_MAP;
                            mem_req <= 1'b0;
                        end
                        else
                        begin
                            abort <= 1'b1;
                        end
                    end
                end
                ST_FETCH_MAP:
                begin
                    if (!mem_req)
                    begin
                        if (shared_va[31:30] != SYS_SPACE
                            || {11'h000, shared_va[PAGE_HI:PAGE_LO]} >= sys_len)
                        begin
                            undefined <= 1'b1;
                            state <= ST_IDLE;
                        end
                        else
                        begin
                            mem_req <= 1'b1;
                            mem_addr <= entry_addr(sys_base, shared_va[PAGE_HI:PAGE_LO]);
                        end
                    end
                    else if (mem_ack)
                    begin
                        if (!mem_rdata[VALID_BIT])
                        begin
                            mem_req <= 1'b0;
                            undefined <= 1'b1;
                            state <= ST_IDLE;
                        end
                        else
                        begin
                            mem_addr <= {mem_rdata[FRAME_HI:0], shared_va[OFFSET_W-1:2],
                                         2'h0};
                            state <= ST_FETCH2;
                        end
                    end
                end
                ST_FETCH2:
                begin
                    if (mem_ack)
                    begin
                        mem_req <= 1'b0;
                        entry_final <= mem_rdata;
                        state <= ST_IDLE;
                        if (io_decode(mem_rdata) != KIND_FRAME)
                        begin
                            undefined <= 1'b1;
                        end
                        else
                        begin
                            paddr_res <= {mem_rdata[FRAME_HI:0], vaddr[OFFSET_W-1:0]};
                            // protection already judged on the first entry
                            if (ctrl_write && ctrl_dirty_en && mem_rdata[VALID_BIT])
                            begin
                                mem_req <= 1'b1;
                                mem_we <= 1'b1;
                                mem_wdata <= mem_rdata | (32'h1 << DIRTY_BIT);
                                state <= ST_WRBACK;
                            end
                        end
                    end
                end
                ST_WRBACK:
                begin
                    if (mem_ack)
                    begin
                        mem_req <= 1'b0;
                        mem_we <= 1'b0;
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
            // walk ends one cycle after the machine falls back to idle; one test
            // instead of mirroring every exit condition of the case above
            if (busy && state == ST_IDLE)
            begin
                busy <= 1'b0;
                done <= 1'b1;
                mem_lock <= 1'b0;
            end
        end
    end
endmodule : map_entry_translator

// file: hw/map_entry_pkg.sv
// constants for the page map entry translator
package map_entry_pkg;
    // ==========================================
    // register byte offsets
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] VADDR_OFFSET = 8'h08;
    localparam logic [7:0] SYS_BASE_OFFSET = 8'h0C;
    localparam logic [7:0] SYS_LEN_OFFSET = 8'h10;
    localparam logic [7:0] SHARED_BASE_OFFSET = 8'h14;
    localparam logic [7:0] PADDR_OFFSET = 8'h18;
    localparam logic [7:0] ENTRY_OFFSET = 8'h1C;
    localparam logic [7:0] FINAL_ENTRY_OFFSET = 8'h20;
    // ==========================================
    // control register bit positions
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_WRITE_BIT = 1;
    localparam int CTRL_DIRTY_EN_BIT = 2;
    localparam int CTRL_ACCESS_CODE_EN_BIT = 3;
    // ==========================================
    // map entry fields
    localparam int VALID_BIT = 31;
    localparam int CODE_HI = 30;
    localparam int CODE_LO = 27;
    localparam int DIRTY_BIT = 26;
    localparam int SHARED_SEL_BIT = 22;
    localparam int FRAME_HI = 20;
    localparam int FRAME_W = 21;
    localparam logic [3:0] CODE_NO_ACCESS = 4'h0;
    localparam logic [3:0] CODE_RESERVED = 4'h1;
    // ==========================================
    // system space address layout
    localparam logic [1:0] SYS_SPACE = 2'h2;
    localparam int PAGE_HI = 29;
    localparam int PAGE_LO = 9;
    localparam int OFFSET_W = 9;
    localparam int PADDR_W = 30;
    // ==========================================
    // reset values and bus answers
    localparam logic [31:0] REG_RESET = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ==========================================
    // enumerations
    typedef enum logic [1:0] {KIND_FRAME = 2'h0, KIND_SHARED = 2'h1, KIND_ABORT = 2'h2}
        entry_kind_type;
    typedef enum logic [2:0]
    {
        ST_IDLE = 3'h0,
        ST_FETCH1 = 3'h1,
        ST_FETCH_MAP = 3'h3,
        ST_FETCH2 = 3'h2,
        ST_WRBACK = 3'h6
    } walk_state_type;
endpackage : map_entry_pkg

// file: tb/map_entry_translator_props.sv
// concurrent property checker for the translator ports
module map_entry_translator_props
    import map_entry_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic mem_lock,
    input wire logic [PADDR_W-1:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] last_read;
    logic [PADDR_W-1:0] last_addr;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // ==========================================
    // last entry read, so a write-back can be judged
    always_ff @(posedge aclk)
    begin
        if (mem_ack && !mem_we)
        begin
            last_read <= mem_rdata;
            last_addr <= mem_addr;
        end
    end
    chk_req_holds: assert property (
        mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_wdata))
        else $error("entry request changed before acknowledge");
    chk_addr_aligned: assert property (mem_req |-> mem_addr[1:0] == 2'h0)
        else $error("entry address not longword aligned");
    chk_write_lock: assert property (mem_req && mem_we |-> mem_lock)
        else $error("entry write without lock");
    chk_writeback_word: assert property (
        mem_req && mem_we |-> mem_wdata == (last_read | 32'h0400_0000) && mem_wdata[31])
        else $error("write-back word differs from read word plus dirty");
    chk_writeback_addr: assert property (mem_req && mem_we |-> mem_addr == last_addr)
        else $error("write-back address differs from read address");
    chk_ack_release: assert property (mem_ack && mem_we |=> !mem_req)
        else $error("request held after write-back");
    chk_read_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read answer late");
    chk_read_gate: assert property (rvalid |-> !arready)
        else $error("read address accepted while answer pending");
endmodule : map_entry_translator_props

bind map_entry_translator map_entry_translator_props props
(
    .aclk, .aresetn, .arvalid, .arready, .rvalid, .mem_req, .mem_we, .mem_lock,
    .mem_addr, .mem_wdata, .mem_ack, .mem_rdata
);

// file: tb/entry_memory.sv
// behavioural page table memory on the entry port
module entry_memory
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [29:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    input wire logic [3:0] delay,
    output logic mem_ack,
    output logic [31:0] mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] words [0:255];
    logic [3:0] waited;
    // ==========================================
    // read data scrambled outside the ack cycle
    always @(posedge aclk)
    begin
        mem_rdata <= aresetn ? ~mem_rdata : 32'h0F0F_0F0F;
        if (!aresetn || !mem_req || mem_ack)
        begin
            waited <= 4'h0;
            mem_ack <= 1'b0;
        end
        else if (waited >= delay)
        begin
            mem_ack <= 1'b1;
            mem_rdata <= words[mem_addr[9:2]];
            if (mem_we)
                words[mem_addr[9:2]] <= mem_wdata;
        end
        else
            waited <= waited + 4'h1;
    end
endmodule : entry_memory

// file: tb/test_io_page_entry_translator.sv
// self-checking bench for the page map entry translator
module test_io_page_entry_translator
    import map_entry_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, va = 32'h8000_07AB;
    logic [3:0] wstrb = 4'hF, delay = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, mem_req, mem_we, mem_lock, mem_ack;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, mem_wdata, mem_rdata;
    logic [PADDR_W-1:0] mem_addr;
    int fails = 0, check_count = 0, acks = 0;
    map_entry_translator dut (.*);
    entry_memory mem (.*);
    always #5 aclk = ~aclk;
    always @(posedge aclk)
        if (mem_ack) acks <= acks + 1;
    // ==========================================
    // bus and compare helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (bvalid && bready) break;
            bready <= 1'b1;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        r = bresp;
        bready <= 1'b0;
    endtask : axi_write
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (rvalid && rready) break;
            rready <= 1'b1;
            if (arready) arvalid <= 1'b0;
        end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : axi_read
    // one walk: entry in word 3, expected status, address, word and memory accesses
    task automatic trial(input logic [31:0] e, input logic [3:0] ctl, input logic [31:0] es,
        input logic [31:0] ep, input logic [31:0] ew, input int ea);
        logic [31:0] st;
        logic [1:0] r;
        int start_acks;
        mem.words[3] = e;
        start_acks = acks;
        axi_write(VADDR_OFFSET, va, r);
        axi_write(CTRL_OFFSET, {28'h0, ctl}, r);
        do
        begin
            axi_read(STATUS_OFFSET, st, r);
        end
        while (st[1] !== 1'b1);
        check(st, es);
        axi_read(PADDR_OFFSET, st, r);
        if (es == 32'h2) check(st, ep);
        check(mem.words[3], ew);
        check(32'(acks - start_acks), 32'(ea));
    endtask : trial
    // ==========================================
    // scenarios
    task automatic t_registers;
        logic [31:0] d;
        logic [1:0] r;
        for (int a = 0; a <= 32; a += 4)
        begin
            axi_read(8'(a), d, r);
            check(d, REG_RESET);
        end
        axi_read(8'h24, d, r);
        check(32'(r), 32'(RESP_SLVERR));
        axi_write(STATUS_OFFSET, 32'hFFFF_FFFF, r);
        check(32'(r), 32'(RESP_SLVERR));
        axi_write(SYS_LEN_OFFSET, 32'h10, r);
        axi_write(SHARED_BASE_OFFSET, 32'h8000_0A00, r);
        axi_read(SHARED_BASE_OFFSET, d, r);
        check(d, 32'h8000_0A00);
    endtask : t_registers
    task automatic t_decode;
        trial(32'hF9E1_2345, 4'h1, 32'h2, 32'h0246_8BAB, 32'hF9E1_2345, 1);
        trial(32'h79A0_0ABC, 4'h1, 32'h2, 32'h0015_79AB, 32'h79A0_0ABC, 1);
        trial(32'h7C00_0ABC, 4'h1, 32'h6, 32'h0, 32'h7C00_0ABC, 1);
        trial(32'h7C40_0ABC, 4'h1, 32'h6, 32'h0, 32'h7C40_0ABC, 1);
    endtask : t_decode
    task automatic t_shared;
        logic [31:0] d;
        logic [1:0] r;
        delay <= 4'h3;
        mem.words[5] = 32'h8000_0000;
        mem.words[2] = 32'h8000_ABCD;
        trial(32'h1840_0002, 4'h9, 32'h2, 32'h0157_9BAB, 32'h1840_0002, 3);
        axi_read(FINAL_ENTRY_OFFSET, d, r);
        check(d, 32'h8000_ABCD);
        mem.words[2] = 32'h0400_0000;
        trial(32'h1840_0002, 4'h1, 32'h22, 32'h0, 32'h1840_0002, 3);
    endtask : t_shared
    task automatic t_access;
        delay <= 4'h1;
        trial(32'h9800_0100, 4'h7, 32'h2, 32'h0002_01AB, 32'h9C00_0100, 2);
        trial(32'h1800_0100, 4'h7, 32'h2, 32'h0002_01AB, 32'h1800_0100, 1);
        trial(32'h8000_0100, 4'hF, 32'h12, 32'h0, 32'h8000_0100, 1);
        trial(32'h0800_0100, 4'hF, 32'h12, 32'h0, 32'h0800_0100, 1);
    endtask : t_access
    task automatic t_space;
        va = 32'hC000_07AB;
        trial(32'h9800_0100, 4'h1, 32'h6, 32'h0, 32'h9800_0100, 0);
        va = 32'h8000_21AB;
        trial(32'h9800_0100, 4'h1, 32'hA, 32'h0, 32'h9800_0100, 0);
    endtask : t_space
    task automatic results;
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : results
    initial
    begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_registers();
        t_decode();
        t_shared();
        t_access();
        t_space();
        results();
    end
    initial
    begin
        #200us;
        fails++;
        results();
    end
endmodule : test_io_page_entry_translator
